// ===== design/fcfs_top.sv
// fieldbus communication fault supervisor: detects link faults and
// reports them latched, with the code of the lowest pending slot; status inputs come from the
// protocol engines, synchronous to clock
`default_nettype none

module fcfs_top #(
  parameter int TICK_CYC = fcfs_pkg::FCFS_TICK_CYC,
  parameter int TICKS_PER_UNIT = fcfs_pkg::FCFS_TICKS_PER_UNIT
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // CAN interface status
  input wire logic can_enable,
  input wire logic can_supply_ok,
  input wire logic can_bus_off,
  // CANopen, DeviceNet, EtherNet/IP status
  input wire logic canopen_operational,
  input wire logic master_run,
  input wire logic io_exchange_active,
  input wire logic dnet_conn_expired,
  input wire logic enip_cyclic_active,
  input wire logic enip_owner_timeout,
  // Modbus TCP
  input wire logic tcp_telegram_ok,
  input wire logic [15:0] tcp_telegram_timeout_setting,
  // fault handler
  input wire logic fault_reset,
  output logic can_comm_enable,
  output logic fault_active,
  output logic [9:0] fault_code,
  output logic [6:0] fault_pending
);
  import fcfs_pkg::*;

  typedef struct packed {
    fcfs_can_type can;
    logic supply_prev;
    logic op_prev;
    logic run_prev;
    logic enip_started;
    logic can_comm_enable;
    logic fault_active;
    logic [9:0] fault_code;
  } fcfs_top_type;
  fcfs_top_type s_q, s_d;

  logic [FCFS_NUM_FAULTS-1:0] detect;
  logic [FCFS_NUM_FAULTS-1:0] pending;
  logic tcp_expire;
  logic [9:0] code_sel;

  fcfs_tcp_watch #(
    .TICK_CYC(TICK_CYC),
    .TICKS_PER_UNIT(TICKS_PER_UNIT)
  ) u_tcp (
    .clock(clock),
    .resetn(resetn),
    .telegram_ok(tcp_telegram_ok),
    .tcp_telegram_timeout_setting(tcp_telegram_timeout_setting),
    .expire(tcp_expire)
  );

  // one latch per fault slot
  genvar gi;
  generate
    for (gi = 0; gi < FCFS_NUM_FAULTS; gi++) begin : g_slot
      fcfs_latch u_latch (
        .clock(clock),
        .resetn(resetn),
        .set_in(detect[gi]),
        .clear_in(fault_reset),
        .flag_out(pending[gi])
      );
    end
  endgenerate

  // fault detection; supply, CANopen and idle are edge based, DeviceNet and owner timeout are level
  always_comb begin
    detect = '0;
    detect[FCFS_SLOT_SUPPLY] = can_enable && !can_supply_ok
      && s_q.supply_prev;
    detect[FCFS_SLOT_BUS_OFF] = s_q.can == FCFS_CAN_RUN && can_bus_off
      && can_enable;
    detect[FCFS_SLOT_CANOPEN] = s_q.op_prev && !canopen_operational;
    // master Run to Idle during exchange
    detect[FCFS_SLOT_IDLE] = io_exchange_active && s_q.run_prev
      && !master_run;
    detect[FCFS_SLOT_DNET] = dnet_conn_expired;
    detect[FCFS_SLOT_ENIP] = s_q.enip_started && enip_owner_timeout;
    detect[FCFS_SLOT_TCP] = tcp_expire;
  end

  // lowest slot wins the reported code
  always_comb begin
    code_sel = '0;
    if (pending[FCFS_SLOT_SUPPLY]) begin
      code_sel = FCFS_CODE_NO_SUPPLY;
    end else if (pending[FCFS_SLOT_BUS_OFF]) begin
      code_sel = FCFS_CODE_BUS_OFF;
    end else if (pending[FCFS_SLOT_CANOPEN]) begin
      code_sel = FCFS_CODE_CANOPEN;
    end else if (pending[FCFS_SLOT_IDLE]) begin
      code_sel = FCFS_CODE_IDLE;
    end else if (pending[FCFS_SLOT_DNET]) begin
      code_sel = FCFS_CODE_DNET;
    end else if (pending[FCFS_SLOT_ENIP]) begin
      code_sel = FCFS_CODE_ENIP;
    end else if (pending[FCFS_SLOT_TCP]) begin
      code_sel = FCFS_CODE_TCP;
    end
  end

  // state update
  always_comb begin
    s_d = s_q;
    s_d.supply_prev = can_supply_ok;
    s_d.op_prev = canopen_operational;
    s_d.run_prev = master_run;
    if (enip_cyclic_active) begin
      s_d.enip_started = 1'b1;
    end
    case (s_q.can)
      FCFS_CAN_RUN: begin
        if (detect[FCFS_SLOT_BUS_OFF]) begin
          s_d.can = FCFS_CAN_BUS_OFF;
        end
      end
      FCFS_CAN_BUS_OFF: begin
        // only a supply drop ends bus-off; fault reset does not
        if (!can_supply_ok) begin
          s_d.can = FCFS_CAN_RUN;
        end
      end
      default: s_d.can = FCFS_CAN_RUN;
    endcase
    s_d.can_comm_enable = can_enable && s_d.can == FCFS_CAN_RUN
      && can_supply_ok;
    s_d.fault_active = |pending;
    s_d.fault_code = code_sel;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{can: FCFS_CAN_RUN, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign can_comm_enable = s_q.can_comm_enable;
  assign fault_active = s_q.fault_active;
  assign fault_code = s_q.fault_code;
  assign fault_pending = pending;

  property p_busoff_silent;
    @(posedge clock) disable iff (!resetn)
    s_q.can == FCFS_CAN_BUS_OFF |=> !can_comm_enable;
  endproperty
  a_busoff_silent: assert property (p_busoff_silent)
    else $error("CAN enabled while bus-off");

  property p_busoff_stays;
    @(posedge clock) disable iff (!resetn)
    (s_q.can == FCFS_CAN_BUS_OFF && can_supply_ok)
      |=> s_q.can == FCFS_CAN_BUS_OFF;
  endproperty
  a_busoff_stays: assert property (p_busoff_stays)
    else $error("bus-off left without supply cycle");

  property p_busoff_code;
    @(posedge clock) disable iff (!resetn)
    detect[FCFS_SLOT_BUS_OFF] |=> pending[FCFS_SLOT_BUS_OFF];
  endproperty
  a_busoff_code: assert property (p_busoff_code)
    else $error("bus-off not latched");

  property p_supply_fault;
    @(posedge clock) disable iff (!resetn)
    (can_enable && $fell(can_supply_ok))
      |=> pending[FCFS_SLOT_SUPPLY];
  endproperty
  a_supply_fault: assert property (p_supply_fault)
    else $error("supply loss not latched");

  property p_canopen;
    @(posedge clock) disable iff (!resetn)
    $fell(canopen_operational) |=> pending[FCFS_SLOT_CANOPEN];
  endproperty
  a_canopen: assert property (p_canopen)
    else $error("CANopen drop not latched");

  property p_idle;
    @(posedge clock) disable iff (!resetn)
    (io_exchange_active && $fell(master_run)) |=> pending[FCFS_SLOT_IDLE];
  endproperty
  a_idle: assert property (p_idle)
    else $error("master idle not latched");

  property p_dnet;
    @(posedge clock) disable iff (!resetn)
    dnet_conn_expired |=> pending[FCFS_SLOT_DNET];
  endproperty
  a_dnet: assert property (p_dnet)
    else $error("DeviceNet expiry not latched");

  property p_enip_gate;
    @(posedge clock) disable iff (!resetn)
    (!s_q.enip_started && !pending[FCFS_SLOT_ENIP])
      |=> !pending[FCFS_SLOT_ENIP];
  endproperty
  a_enip_gate: assert property (p_enip_gate)
    else $error("owner timeout before cyclic start");

  property p_code;
    @(posedge clock) disable iff (!resetn)
    (pending == 7'h40) |=> fault_code == FCFS_CODE_TCP;
  endproperty
  a_code: assert property (p_code)
    else $error("wrong code for Modbus TCP timeout");

  // bus-off entry and exit, both directions
  property p_busoff_enter;
    @(posedge clock) disable iff (!resetn)
    (can_enable && can_bus_off && s_q.can == FCFS_CAN_RUN)
      |=> s_q.can == FCFS_CAN_BUS_OFF;
  endproperty
  a_busoff_enter: assert property (p_busoff_enter)
    else $error("bus-off not entered");

  property p_supply_exit;
    @(posedge clock) disable iff (!resetn)
    (s_q.can == FCFS_CAN_BUS_OFF && !can_supply_ok)
      |=> s_q.can == FCFS_CAN_RUN;
  endproperty
  a_supply_exit: assert property (p_supply_exit)
    else $error("supply cycle did not leave bus-off");

  // a disabled interface never counts a bus-off
  property p_busoff_needs_enable;
    @(posedge clock) disable iff (!resetn)
    (!can_enable && s_q.can == FCFS_CAN_RUN)
      |=> s_q.can == FCFS_CAN_RUN;
  endproperty
  a_busoff_needs_enable: assert property (p_busoff_needs_enable)
    else $error("bus-off taken while interface disabled");

  // no supply means no CAN traffic, whatever the state
  property p_no_supply_quiet;
    @(posedge clock) disable iff (!resetn)
    !can_supply_ok |=> !can_comm_enable;
  endproperty
  a_no_supply_quiet: assert property (p_no_supply_quiet)
    else $error("CAN enabled without supply");

  // owner timeout and telegram expiry reach their latches
  property p_enip_fault;
    @(posedge clock) disable iff (!resetn)
    (s_q.enip_started && enip_owner_timeout)
      |=> pending[FCFS_SLOT_ENIP];
  endproperty
  a_enip_fault: assert property (p_enip_fault)
    else $error("owner timeout not latched");

  property p_tcp_fault;
    @(posedge clock) disable iff (!resetn)
    tcp_expire |=> pending[FCFS_SLOT_TCP];
  endproperty
  a_tcp_fault: assert property (p_tcp_fault)
    else $error("telegram timeout not latched");

  // fault reset empties every latch unless a new fault lands
  property p_reset_clears;
    @(posedge clock) disable iff (!resetn)
    (fault_reset && detect == '0) |=> pending == '0;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("fault reset left a latch set");

  // summary outputs follow the latches one edge later
  property p_active;
    @(posedge clock) disable iff (!resetn)
    (|pending) |=> fault_active;
  endproperty
  a_active: assert property (p_active)
    else $error("fault latched but not active");

  property p_quiet;
    @(posedge clock) disable iff (!resetn)
    (pending == '0) |=> (!fault_active && fault_code == 10'h000);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("fault shown with no latch set");

  // supply loss outranks every other code
  property p_code_first;
    @(posedge clock) disable iff (!resetn)
    pending[FCFS_SLOT_SUPPLY] |=> fault_code == FCFS_CODE_NO_SUPPLY;
  endproperty
  a_code_first: assert property (p_code_first)
    else $error("supply fault code not on top");

  // a healthy enabled link keeps communicating
  property p_comm_runs;
    @(posedge clock) disable iff (!resetn)
    (can_enable && can_supply_ok && !can_bus_off
      && s_q.can == FCFS_CAN_RUN) |=> can_comm_enable;
  endproperty
  a_comm_runs: assert property (p_comm_runs)
    else $error("healthy CAN link not enabled");
endmodule

`default_nettype wire

// ===== design/fcfs_pkg.sv
// constants and types for the fieldbus communication fault supervisor
// assumes one system clock at 250 MHz and an asynchronous active-low reset
//
// Functional notes
// - with the CAN interface enabled, an interface supply that drops raises 233.
// - a CAN controller that goes bus-off raises 234; the code raises it only while can_enable is set.
// - once bus-off, all CAN traffic stops and the interface stays disabled.
// - only a power cycle or a CAN supply drop and return ends bus-off.
// - a CANopen node falling from operational to pre-operational raises 235.
// - a master seen going from Run to Idle while exchanging data raises 236.
// - any DeviceNet I/O connection that expires raises 237.
// - after cyclic exchange starts, an owner connection timeout raises 247.
// - no valid Modbus TCP telegram for longer than the setting raises 249.
// - the telegram timer starts at the first valid telegram, restarts on each.
// - a timeout setting of zero switches the telegram supervision off.
`default_nettype none

package fcfs_pkg;
  // fault codes reported to the drive fault handler
  localparam logic [9:0] FCFS_CODE_NO_SUPPLY = 10'h0E9;
  localparam logic [9:0] FCFS_CODE_BUS_OFF = 10'h0EA;
  localparam logic [9:0] FCFS_CODE_CANOPEN = 10'h0EB;
  localparam logic [9:0] FCFS_CODE_IDLE = 10'h0EC;
  localparam logic [9:0] FCFS_CODE_DNET = 10'h0ED;
  localparam logic [9:0] FCFS_CODE_ENIP = 10'h0F7;
  localparam logic [9:0] FCFS_CODE_TCP = 10'h0F9;
  // fault slot positions in the pending vector
  localparam int FCFS_SLOT_SUPPLY = 0;
  localparam int FCFS_SLOT_BUS_OFF = 1;
  localparam int FCFS_SLOT_CANOPEN = 2;
  localparam int FCFS_SLOT_IDLE = 3;
  localparam int FCFS_SLOT_DNET = 4;
  localparam int FCFS_SLOT_ENIP = 5;
  localparam int FCFS_SLOT_TCP = 6;
  localparam int FCFS_NUM_FAULTS = 7;
  // timeout setting unit 0.1 s, counted through a 100 us tick
  localparam int FCFS_CLK_MHZ = 250;
  localparam int FCFS_TICK_US = 100;
  localparam int FCFS_TICK_CYC = FCFS_CLK_MHZ * FCFS_TICK_US;
  localparam int FCFS_TICKS_PER_UNIT = 1000;
  localparam logic [15:0] FCFS_TIMEOUT_OFF = 16'h0000;
  // node states
  typedef enum logic [1:0] {
    FCFS_CAN_RUN,
    FCFS_CAN_BUS_OFF
  } fcfs_can_type;
endpackage

`default_nettype wire

// ===== design/fcfs_latch.sv
// one latched fault slot: sets on a detect pulse, clears on fault reset
// assumes detect is synchronous; set wins over a clear in the same cycle
`default_nettype none

module fcfs_latch (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // set and clear
  input wire logic set_in,
  input wire logic clear_in,
  // state
  output logic flag_out
);
  typedef struct packed {
    logic flag;
  } fcfs_latch_type;
  fcfs_latch_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (set_in) begin
      s_d.flag = 1'b1;
    end else if (clear_in) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_out = s_q.flag;

  property p_set_holds;
    @(posedge clock) disable iff (!resetn)
    set_in |=> flag_out;
  endproperty
  a_set_holds: assert property (p_set_holds)
    else $error("latched fault lost after set");
endmodule

`default_nettype wire

// ===== design/fcfs_tcp_watch.sv
// Modbus TCP telegram watchdog: arms on the first valid telegram
// assumes setting is in 0.1 s steps and stays stable while armed
`default_nettype none

module fcfs_tcp_watch #(
  parameter int TICK_CYC = fcfs_pkg::FCFS_TICK_CYC,
  parameter int TICKS_PER_UNIT = fcfs_pkg::FCFS_TICKS_PER_UNIT
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // telegram side
  input wire logic telegram_ok,
  input wire logic [15:0] tcp_telegram_timeout_setting,
  // expiry pulse
  output logic expire
);
  import fcfs_pkg::*;
  typedef struct packed {
    logic armed;
    logic [15:0] pre;
    logic [9:0] tick;
    logic [15:0] units;
    logic expire;
  } fcfs_tcp_type;
  fcfs_tcp_type s_q, s_d;
  logic off;

  assign off = tcp_telegram_timeout_setting == FCFS_TIMEOUT_OFF;

  // prescaler, tick and unit counters
  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    if (off) begin
      s_d.armed = 1'b0;
      s_d.pre = '0;
      s_d.tick = '0;
      s_d.units = '0;
    end else if (telegram_ok) begin
      s_d.armed = 1'b1;
      s_d.pre = '0;
      s_d.tick = '0;
      s_d.units = '0;
    end else if (s_q.armed) begin
      if (s_q.pre == 16'(TICK_CYC - 1)) begin
        s_d.pre = '0;
        if (s_q.tick == 10'(TICKS_PER_UNIT - 1)) begin
          s_d.tick = '0;
          s_d.units = s_q.units + 16'h0001;
          if (s_q.units + 16'h0001 >= tcp_telegram_timeout_setting) begin
            s_d.expire = 1'b1;
            s_d.armed = 1'b0; // one report per silence
          end
        end else begin
          s_d.tick = s_q.tick + 10'h001;
        end
      end else begin
        s_d.pre = s_q.pre + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expire = s_q.expire;

  property p_off_quiet;
    @(posedge clock) disable iff (!resetn)
    off |=> !expire;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("timeout fired while supervision off");

  property p_telegram_restarts;
    @(posedge clock) disable iff (!resetn)
    telegram_ok |=> !expire ##0 (s_q.units == 16'h0000);
  endproperty
  a_telegram_restarts: assert property (p_telegram_restarts)
    else $error("valid telegram did not restart timer");
endmodule

`default_nettype wire

// ===== verif/fcfs_master_model.sv
// network master and Modbus TCP client seen from the supervisor
// assumes the bench sets the command inputs just after a falling edge
`default_nettype none

module fcfs_master_model (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // bench commands
  input wire logic run_cmd,
  input wire logic hb_ok,
  input wire logic [7:0] tcp_gap,
  // toward the supervisor
  output logic master_run,
  output logic canopen_operational,
  output logic tcp_telegram_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] gap_cnt_q;

  // guarding kept in time
  // node stays operational only while heartbeats arrive
  assign canopen_operational = hb_ok;
  assign master_run = run_cmd;

  // telegrams within timeout
  // gap of zero means the client has gone silent
  always @(negedge clock or negedge resetn) begin
    if (!resetn) begin
      gap_cnt_q <= 8'h00;
      tcp_telegram_ok <= 1'b0;
    end else if (tcp_gap != 8'h00 && gap_cnt_q >= tcp_gap - 8'h01) begin
      gap_cnt_q <= 8'h00;
      tcp_telegram_ok <= 1'b1;
    end else begin
      gap_cnt_q <= gap_cnt_q + 8'h01;
      tcp_telegram_ok <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== verif/fcfs_top_tb_top.sv
// self-checking bench for the communication fault supervisor
// assumes sim timing of 4 cycles a tick and 4 ticks a unit
`default_nettype none

module fcfs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fcfs_pkg::*;

  logic clock, resetn, can_enable, can_supply_ok, can_bus_off;
  logic canopen_operational, master_run, io_exchange_active;
  logic dnet_conn_expired, enip_cyclic_active, enip_owner_timeout;
  logic tcp_telegram_ok, fault_reset, can_comm_enable, fault_active;
  logic run_cmd, hb_ok;
  logic [7:0] tcp_gap;
  logic [15:0] setting;
  logic [9:0] fault_code;
  logic [6:0] fault_pending;
  int miscompares = 0;
  int n_compared = 0;
  int n;
  int m;

  fcfs_top #(.TICK_CYC(4), .TICKS_PER_UNIT(4)) fcfs_top_i (
    .clock(clock), .resetn(resetn), .can_enable(can_enable),
    .can_supply_ok(can_supply_ok), .can_bus_off(can_bus_off),
    .canopen_operational(canopen_operational), .master_run(master_run),
    .io_exchange_active(io_exchange_active),
    .dnet_conn_expired(dnet_conn_expired),
    .enip_cyclic_active(enip_cyclic_active),
    .enip_owner_timeout(enip_owner_timeout),
    .tcp_telegram_ok(tcp_telegram_ok),
    .tcp_telegram_timeout_setting(setting), .fault_reset(fault_reset),
    .can_comm_enable(can_comm_enable), .fault_active(fault_active),
    .fault_code(fault_code), .fault_pending(fault_pending));

  fcfs_master_model fcfs_master_model_i (
    .clock(clock), .resetn(resetn), .run_cmd(run_cmd), .hb_ok(hb_ok),
    .tcp_gap(tcp_gap), .master_run(master_run),
    .canopen_operational(canopen_operational),
    .tcp_telegram_ok(tcp_telegram_ok));

  // 250 MHz system clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  // pending one edge after the cause, code one edge later
  task automatic expect_fault(input int slot, input logic [9:0] code);
    cyc(1);
    chk(16'(fault_pending[slot]), 16'h0001);
    cyc(1);
    chk(16'(fault_active), 16'h0001);
    chk(16'(fault_code), 16'(code));
  endtask

  task automatic clear_all;
    fault_reset = 1'b1;
    cyc(1);
    fault_reset = 1'b0;
    cyc(1);
    chk(16'(fault_pending), 16'h0000);
    chk(16'(fault_code), 16'h0000);
  endtask

  task automatic t_supply;
    can_supply_ok = 1'b0;
    expect_fault(FCFS_SLOT_SUPPLY, FCFS_CODE_NO_SUPPLY);
    can_supply_ok = 1'b1;
    cyc(5);
    chk(16'(fault_pending[0]), 16'h0001);
    clear_all();
    // supply loss with the interface off is no fault
    can_enable = 1'b0;
    cyc(1);
    can_supply_ok = 1'b0;
    cyc(3);
    chk(16'(fault_pending), 16'h0000);
    can_supply_ok = 1'b1;
    can_enable = 1'b1;
    cyc(3);
  endtask

  task automatic t_bus_off;
    chk(16'(can_comm_enable), 16'h0001);
    can_bus_off = 1'b1;
    expect_fault(FCFS_SLOT_BUS_OFF, FCFS_CODE_BUS_OFF);
    chk(16'(can_comm_enable), 16'h0000);
    can_bus_off = 1'b0;
    clear_all();
    cyc(5);
    chk(16'(can_comm_enable), 16'h0000);
    can_supply_ok = 1'b0;
    cyc(1);
    can_supply_ok = 1'b1;
    cyc(2);
    chk(16'(can_comm_enable), 16'h0001);
    clear_all();
    // a power cycle also leaves bus-off
    can_bus_off = 1'b1;
    cyc(1);
    chk(16'(can_comm_enable), 16'h0000);
    can_bus_off = 1'b0;
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(1);
    chk(16'(can_comm_enable), 16'h0001);
    chk(16'(fault_pending), 16'h0000);
  endtask

  task automatic t_node_events;
    hb_ok = 1'b0;
    expect_fault(FCFS_SLOT_CANOPEN, FCFS_CODE_CANOPEN);
    hb_ok = 1'b1;
    clear_all();
    io_exchange_active = 1'b1;
    run_cmd = 1'b1;
    cyc(3);
    run_cmd = 1'b0;
    expect_fault(FCFS_SLOT_IDLE, FCFS_CODE_IDLE);
    io_exchange_active = 1'b0;
    clear_all();
    dnet_conn_expired = 1'b1;
    expect_fault(FCFS_SLOT_DNET, FCFS_CODE_DNET);
    // a lower slot takes over the code while 237 stays latched
    dnet_conn_expired = 1'b0;
    hb_ok = 1'b0;
    cyc(2);
    chk(16'(fault_pending), 16'h0014);
    chk(16'(fault_code), 16'(FCFS_CODE_CANOPEN));
    hb_ok = 1'b1;
    clear_all();
  endtask

  task automatic t_enip;
    // a timeout before cyclic exchange ever ran is ignored
    enip_owner_timeout = 1'b1;
    cyc(3);
    chk(16'(fault_pending), 16'h0000);
    enip_owner_timeout = 1'b0;
    enip_cyclic_active = 1'b1;
    cyc(2);
    enip_owner_timeout = 1'b1;
    expect_fault(FCFS_SLOT_ENIP, FCFS_CODE_ENIP);
    enip_owner_timeout = 1'b0;
    enip_cyclic_active = 1'b0;
    clear_all();
  endtask

  // one setting unit is 16 cycles here, so a setting of 2 is 32
  task automatic t_tcp;
    setting = 16'h0002;
    cyc(100);
    chk(16'(fault_pending), 16'h0000);
    tcp_gap = 8'h08;
    cyc(100);
    chk(16'(fault_pending), 16'h0000);
    // silence starts right after a telegram the design has taken
    m = 0;
    while (tcp_telegram_ok !== 1'b1 && m < 20) begin
      cyc(1);
      m++;
    end
    tcp_gap = 8'h00;
    n = 0;
    while (fault_pending[FCFS_SLOT_TCP] !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk(16'(n > 32 && n < 36), 16'h0001);
    chk(16'(fault_pending[FCFS_SLOT_TCP]), 16'h0001);
    clear_all();
    setting = FCFS_TIMEOUT_OFF;
    tcp_gap = 8'h08;
    cyc(20);
    tcp_gap = 8'h00;
    cyc(100);
    chk(16'(fault_pending), 16'h0000);
  endtask

  // cut a hang short well past the expected run time
  initial begin
    #20000;
    miscompares++;
    test_done();
  end

  initial begin
    resetn = 1'b0;
    can_enable = 1'b1;
    can_supply_ok = 1'b1;
    can_bus_off = 1'b0;
    io_exchange_active = 1'b0;
    dnet_conn_expired = 1'b0;
    enip_cyclic_active = 1'b0;
    enip_owner_timeout = 1'b0;
    fault_reset = 1'b0;
    run_cmd = 1'b0;
    hb_ok = 1'b1;
    tcp_gap = 8'h00;
    setting = 16'h0002;
    cyc(10);
    resetn = 1'b1;
    cyc(1);
    chk(16'(fault_pending), 16'h0000);
    cyc(3);
    t_supply();
    t_bus_off();
    t_node_events();
    t_enip();
    t_tcp();
    test_done();
  end
endmodule

`default_nettype wire
